// [pkg/vol_ctrl_pkg.sv]
package vol_ctrl_pkg;

  localparam logic [7:0] OFS_PROGRAM_HIGHZ = 8'h40;
  localparam logic [7:0] OFS_PROCESSING = 8'h46;
  localparam logic [7:0] OFS_VOLUME_LEVEL = 8'h4c;
  localparam logic [7:0] OFS_RAMP_NORMAL = 8'h4e;
  localparam logic [7:0] OFS_RAMP_EMERG = 8'h4f;

  localparam logic [7:0] RST_PROGRAM_HIGHZ = 8'h01;
  localparam logic [7:0] RST_PROCESSING = 8'h01;
  localparam logic [7:0] RST_VOLUME_LEVEL = 8'h30;
  localparam logic [7:0] RST_RAMP_NORMAL = 8'h33;
  localparam logic [7:0] RST_RAMP_EMERG = 8'h30;

  // field positions
  localparam int BIT_FORCE_LEFT = 3;
  localparam int BIT_FORCE_RIGHT = 2;
  localparam int BIT_BUILTIN_COEFF = 0;
  localparam int POS_DOWN_RATE = 6;
  localparam int POS_DOWN_INC = 4;
  localparam int POS_UP_RATE = 2;
  localparam int POS_UP_INC = 0;

  // processing_control: writable bits 7-3 and 0, bits 2-1 read zero
  localparam logic [7:0] MASK_PROCESSING = 8'hf9;

  localparam logic [7:0] VOL_MUTE_CODE = 8'hff;
  localparam logic [7:0] VOL_MIN_CODE = 8'hfe;
  localparam logic [1:0] RATE_INSTANT = 2'b11;

  // processing program select
  typedef enum logic [1:0] {
    PGM_RAM = 2'b00,
    PGM_ROM1 = 2'b01,
    PGM_ROM2 = 2'b10,
    PGM_ROM3 = 2'b11
  } program_sel_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] increment;
  } ramp_cfg_t;

  typedef struct packed {
    logic         left_highz;
    logic         right_highz;
    program_sel_t program_sel;
    logic         builtin_coeff_select;
  } dsp_cfg_t;

  // code steps of 0.5 dB per update for increment codes 00..11
  function automatic logic [7:0] step_codes(input logic [1:0] inc);
    unique case (inc)
      2'b00: step_codes = 8'h08;
      2'b01: step_codes = 8'h04;
      2'b10: step_codes = 8'h02;
      2'b11: step_codes = 8'h01;
    endcase
  endfunction

  // sample periods per update: 1, 2, 4
  function automatic logic [2:0] rate_periods(input logic [1:0] rate);
    unique case (rate)
      2'b00: rate_periods = 3'd1;
      2'b01: rate_periods = 3'd2;
      2'b10: rate_periods = 3'd4;
      2'b11: rate_periods = 3'd1;
    endcase
  endfunction

endpackage

// [hdl/volume_ramp.sv]
`timescale 1ns/10ps
module volume_ramp
  import vol_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic [7:0] target_code,
  input wire logic emergency,
  input vol_ctrl_pkg::ramp_cfg_t down_cfg,
  input vol_ctrl_pkg::ramp_cfg_t up_cfg,
  input vol_ctrl_pkg::ramp_cfg_t emerg_cfg,
  output logic [7:0] applied_code,
  output logic ramping
);
  logic [7:0] cur_reg, cur_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] tgt_eff;
  logic [7:0] step;
  logic [8:0] moved;
  ramp_cfg_t cfg;
  logic going_down;

  always_comb begin
    tgt_eff = emergency ? VOL_MUTE_CODE : target_code;
    going_down = tgt_eff > cur_reg;
    cfg = emergency ? emerg_cfg : (going_down ? down_cfg : up_cfg);
    step = step_codes(cfg.increment);
    cur_next = cur_reg;
    cnt_next = cnt_reg;
    moved = 9'h000;
    if (cur_reg != tgt_eff) begin
      if (cfg.rate == RATE_INSTANT) begin
        cur_next = tgt_eff;
        cnt_next = 3'd0;
      end else if (sample_tick) begin
        if (cnt_reg + 3'd1 >= rate_periods(cfg.rate)) begin
          cnt_next = 3'd0;
          if (going_down) begin
            moved = {1'b0, cur_reg} + {1'b0, step};
            // stop at target, no overshoot
            cur_next = (moved >= {1'b0, tgt_eff}) ? tgt_eff : moved[7:0];
          end else begin
            moved = {1'b0, cur_reg} - {1'b0, step};
            cur_next = (moved[8] || moved[7:0] <= tgt_eff) ? tgt_eff : moved[7:0];
          end
        end else begin
          cnt_next = cnt_reg + 3'd1;
        end
      end
    end else begin
      cnt_next = 3'd0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur_reg <= RST_VOLUME_LEVEL;
      cnt_reg <= 3'd0;
    end else begin
      cur_reg <= cur_next;
      cnt_reg <= cnt_next;
    end
  end

  assign applied_code = cur_reg;
  assign ramping = cur_reg != tgt_eff;

  a_no_overshoot_dn: assert property (@(posedge clk_sys) disable iff (reset)
    (cur_reg < tgt_eff) |=> (cur_reg <= $past(tgt_eff)) || $changed(tgt_eff))
    else $error("volume ramp overshot target going down");
  a_instant_jump: assert property (@(posedge clk_sys) disable iff (reset)
    (ramping && cfg.rate == RATE_INSTANT) |=> cur_reg == $past(tgt_eff))
    else $error("instant rate did not jump to target");
endmodule

// [hdl/dsp_mode_and_volume_ramp_ctrl.sv]
`timescale 1ns/10ps
module dsp_mode_and_volume_ramp_ctrl
  import vol_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input vol_ctrl_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sample_tick,
  input wire logic parallel_bridge_mode,
  input wire logic emergency_mute,
  input wire logic left_state_highz,
  input wire logic right_state_highz,
  output vol_ctrl_pkg::dsp_cfg_t dsp_cfg,
  output logic left_out_highz,
  output logic right_out_highz,
  output logic [7:0] left_gain_code,
  output logic [7:0] right_gain_code,
  output logic audio_muted,
  output logic volume_ramping
);
  logic [7:0] pgm_reg, pgm_next;
  logic [7:0] proc_reg, proc_next;
  logic [7:0] vol_reg, vol_next;
  logic [7:0] rampn_reg, rampn_next;
  logic [7:0] rampe_reg, rampe_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic parallel_bridge_mode_s1_reg, parallel_bridge_mode_reg;
  logic emerg_s1_reg, emerg_reg;
  logic [7:0] applied;
  logic force_l, force_r;

  // register writes
  always_comb begin
    pgm_next = pgm_reg;
    proc_next = proc_reg;
    vol_next = vol_reg;
    rampn_next = rampn_reg;
    rampe_next = rampe_reg;
    if (reg_req.wr_en) begin
      unique case (reg_req.addr)
        OFS_PROGRAM_HIGHZ: pgm_next = reg_req.wdata;
        OFS_PROCESSING: proc_next = reg_req.wdata & MASK_PROCESSING;
        OFS_VOLUME_LEVEL: vol_next = reg_req.wdata;
        OFS_RAMP_NORMAL: rampn_next = reg_req.wdata;
        OFS_RAMP_EMERG: rampe_next = reg_req.wdata;
        default: ;
      endcase
    end
  end

  // register reads, one cycle latency, unmapped reads zero
  always_comb begin
    rvalid_next = reg_req.rd_en;
    rdata_next = rdata_reg;
    if (reg_req.rd_en) begin
      unique case (reg_req.addr)
        OFS_PROGRAM_HIGHZ: rdata_next = pgm_reg;
        OFS_PROCESSING: rdata_next = proc_reg;
        OFS_VOLUME_LEVEL: rdata_next = vol_reg;
        OFS_RAMP_NORMAL: rdata_next = rampn_reg;
        OFS_RAMP_EMERG: rdata_next = rampe_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pgm_reg <= RST_PROGRAM_HIGHZ;
      proc_reg <= RST_PROCESSING;
      vol_reg <= RST_VOLUME_LEVEL;
      rampn_reg <= RST_RAMP_NORMAL;
      rampe_reg <= RST_RAMP_EMERG;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      pgm_reg <= pgm_next;
      proc_reg <= proc_next;
      vol_reg <= vol_next;
      rampn_reg <= rampn_next;
      rampe_reg <= rampe_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      parallel_bridge_mode_s1_reg <= 1'b0;
      parallel_bridge_mode_reg <= 1'b0;
      emerg_s1_reg <= 1'b0;
      emerg_reg <= 1'b0;
    end else begin
      parallel_bridge_mode_s1_reg <= parallel_bridge_mode;
      parallel_bridge_mode_reg <= parallel_bridge_mode_s1_reg;
      emerg_s1_reg <= emergency_mute;
      emerg_reg <= emerg_s1_reg;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // force bits gated off in bridge mode
  assign force_l = pgm_reg[BIT_FORCE_LEFT] && !parallel_bridge_mode_reg;
  assign force_r = pgm_reg[BIT_FORCE_RIGHT] && !parallel_bridge_mode_reg;
  assign left_out_highz = force_l || left_state_highz;
  assign right_out_highz = force_r || right_state_highz;

  always_comb begin
    dsp_cfg.left_highz = force_l;
    dsp_cfg.right_highz = force_r;
    dsp_cfg.program_sel = program_sel_t'(pgm_reg[1:0]);
    dsp_cfg.builtin_coeff_select = proc_reg[BIT_BUILTIN_COEFF];
  end

  volume_ramp u_ramp (
    .clk_sys(clk_sys),
    .reset(reset),
    .sample_tick(sample_tick),
    .target_code(vol_reg),
    .emergency(emerg_reg),
    .down_cfg(ramp_cfg_t'({rampn_reg[POS_DOWN_RATE +: 2], rampn_reg[POS_DOWN_INC +: 2]})),
    .up_cfg(ramp_cfg_t'({rampn_reg[POS_UP_RATE +: 2], rampn_reg[POS_UP_INC +: 2]})),
    .emerg_cfg(ramp_cfg_t'({rampe_reg[POS_DOWN_RATE +: 2], rampe_reg[POS_DOWN_INC +: 2]})),
    .applied_code(applied),
    .ramping(volume_ramping)
  );

  assign left_gain_code = applied;
  assign right_gain_code = applied;
  assign audio_muted = applied == VOL_MUTE_CODE;

  a_force_left_hz: assert property (@(posedge clk_sys) disable iff (reset)
    (pgm_reg[BIT_FORCE_LEFT] && !parallel_bridge_mode_reg) |-> left_out_highz)
    else $error("left force bit did not hold highz");
  a_force_right_hz: assert property (@(posedge clk_sys) disable iff (reset)
    (pgm_reg[BIT_FORCE_RIGHT] && !parallel_bridge_mode_reg) |-> right_out_highz)
    else $error("right force bit did not hold highz");
  a_force_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    (pgm_reg[BIT_FORCE_LEFT] && !(reg_req.wr_en && reg_req.addr == OFS_PROGRAM_HIGHZ))
    |=> pgm_reg[BIT_FORCE_LEFT])
    else $error("left force released without a write");
  a_force_sticky_r: assert property (@(posedge clk_sys) disable iff (reset)
    (pgm_reg[BIT_FORCE_RIGHT] && !(reg_req.wr_en && reg_req.addr == OFS_PROGRAM_HIGHZ))
    |=> pgm_reg[BIT_FORCE_RIGHT])
    else $error("right force released without a write");
  a_bridge_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    parallel_bridge_mode_reg |-> !dsp_cfg.left_highz && !dsp_cfg.right_highz)
    else $error("force highz active in bridge mode");
  a_program_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_req.wr_en && reg_req.addr == OFS_PROGRAM_HIGHZ)
    |=> dsp_cfg.program_sel == $past(reg_req.wdata[1:0]))
    else $error("program select not taken from write");
  a_coeff_select: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_req.wr_en && reg_req.addr == OFS_PROCESSING)
    |=> dsp_cfg.builtin_coeff_select == $past(reg_req.wdata[0]))
    else $error("coefficient select not taken from write");
  a_shared_gain: assert property (@(posedge clk_sys) disable iff (reset)
    left_gain_code == right_gain_code)
    else $error("channels gain differ");
  a_mute_code: assert property (@(posedge clk_sys) disable iff (reset)
    audio_muted == (left_gain_code == 8'hff))
    else $error("mute flag mismatch");
  a_read_latency: assert property (@(posedge clk_sys) disable iff (reset)
    reg_req.rd_en |=> reg_rvalid)
    else $error("read answer not one cycle later");
endmodule

// [verification/host_model.sv]
`timescale 1ns/10ps
module host_model
  import vol_ctrl_pkg::*;
(
  input wire logic clk_sys,
  output vol_ctrl_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '{1'b0, 1'b0, 8'h00, 8'h00};
  // idle bus shows inverted address and data
  task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req <= '{w, r, a, d};
    @(negedge clk_sys);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    drive(1'b0, 1'b1, a, 8'h00);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

// [verification/dsp_mode_and_volume_ramp_ctrl_tb.sv]
`timescale 1ns/10ps
module dsp_mode_and_volume_ramp_ctrl_tb;
  import vol_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sample_tick = 1'b0;
  logic parallel_bridge_mode = 1'b0;
  logic emergency_mute = 1'b0;
  logic left_state_highz = 1'b0;
  logic right_state_highz = 1'b0;
  reg_req_t reg_req;
  dsp_cfg_t dsp_cfg;
  logic [7:0] reg_rdata, left_gain_code, right_gain_code, rv, cur;
  logic reg_rvalid, left_out_highz, right_out_highz, audio_muted, volume_ramping;
  int miscompares = 0;
  int n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  dsp_mode_and_volume_ramp_ctrl dsp_mode_and_volume_ramp_ctrl_i (
    .clk_sys, .reset, .reg_req, .reg_rdata, .reg_rvalid, .sample_tick,
    .parallel_bridge_mode, .emergency_mute, .left_state_highz, .right_state_highz,
    .dsp_cfg, .left_out_highz, .right_out_highz, .left_gain_code, .right_gain_code,
    .audio_muted, .volume_ramping
  );
  host_model host_model_i (.clk_sys, .reg_req, .reg_rdata, .reg_rvalid);
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_i.wr(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_model_i.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic [7:0] hz();
    return {6'h00, left_out_highz, right_out_highz};
  endfunction
  // ticks until the gain reaches tgt or lim ticks pass, checking each step
  task automatic ramp(input logic [7:0] tgt, input int per, input int st, input int lim);
    int k;
    int d;
    k = 0;
    while (cur !== tgt && k < lim) begin
      @(negedge clk_sys);
      sample_tick = 1'b1;
      @(negedge clk_sys);
      sample_tick = 1'b0;
      k++;
      if (k % per == 0) begin
        d = int'(tgt) - int'(cur);
        d = (d > st) ? st : ((d < -st) ? -st : d);
        cur = 8'(int'(cur) + d);
      end
      chk(left_gain_code, cur);
      chk(right_gain_code, cur);
      chk(8'(volume_ramping), 8'(cur != tgt));
    end
  endtask
  task automatic t_reset_values();
    rchk(OFS_PROGRAM_HIGHZ, 8'h01);
    rchk(OFS_PROCESSING, 8'h01);
    rchk(OFS_VOLUME_LEVEL, 8'h30);
    rchk(OFS_RAMP_NORMAL, 8'h33);
    rchk(OFS_RAMP_EMERG, 8'h30);
    chk(left_gain_code, 8'h30);
    wr(8'h41, 8'h5a);
    rchk(8'h41, 8'h00);
  endtask
  task automatic t_program_coeff();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PROGRAM_HIGHZ, 8'(i));
      chk(8'(dsp_cfg.program_sel), 8'(i));
    end
    wr(OFS_PROCESSING, 8'hff);
    rchk(OFS_PROCESSING, 8'hf9);
    chk(8'(dsp_cfg.builtin_coeff_select), 8'h01);
    wr(OFS_PROCESSING, 8'h00);
    chk(8'(dsp_cfg.builtin_coeff_select), 8'h00);
  endtask
  task automatic t_highz();
    wr(OFS_PROGRAM_HIGHZ, 8'h08);
    chk(hz(), 8'h02);
    chk(8'({dsp_cfg.left_highz, dsp_cfg.right_highz}), 8'h02);
    wr(OFS_PROGRAM_HIGHZ, 8'h04);
    chk(hz(), 8'h01);
    chk(8'({dsp_cfg.left_highz, dsp_cfg.right_highz}), 8'h01);
    wr(OFS_PROGRAM_HIGHZ, 8'h0e);
    right_state_highz = 1'b1;
    wr(OFS_PROCESSING, 8'h01);
    right_state_highz = 1'b0;
    wr(OFS_VOLUME_LEVEL, 8'h30);
    chk(hz(), 8'h03);
    parallel_bridge_mode = 1'b1;
    clks(3);
    chk(hz(), 8'h00);
    chk(8'({dsp_cfg.left_highz, dsp_cfg.right_highz}), 8'h00);
    left_state_highz = 1'b1;
    clks(1);
    chk(hz(), 8'h02);
    left_state_highz = 1'b0;
    parallel_bridge_mode = 1'b0;
    wr(OFS_PROGRAM_HIGHZ, 8'h01);
    clks(3);
    chk(hz(), 8'h00);
  endtask
  task automatic t_ramp_steps();
    cur = 8'h30;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_RAMP_NORMAL, 8'((i % 3) * 68 + i * 17));
      wr(OFS_VOLUME_LEVEL, 8'h3b);
      ramp(8'h3b, 1 << (i % 3), 8 >> i, 400);
      wr(OFS_VOLUME_LEVEL, 8'h30);
      ramp(8'h30, 1 << (i % 3), 8 >> i, 400);
    end
    // down and up fields differ, so a swap of the two would show
    wr(OFS_RAMP_NORMAL, 8'h1b);
    wr(OFS_VOLUME_LEVEL, 8'h38);
    ramp(8'h38, 1, 4, 400);
    wr(OFS_VOLUME_LEVEL, 8'h30);
    ramp(8'h30, 4, 1, 400);
  endtask
  task automatic t_instant_restart();
    wr(OFS_RAMP_NORMAL, 8'hcc);
    wr(OFS_VOLUME_LEVEL, 8'hff);
    clks(2);
    chk(left_gain_code, 8'hff);
    chk(8'(audio_muted), 8'h01);
    wr(OFS_VOLUME_LEVEL, 8'h00);
    clks(2);
    chk(right_gain_code, 8'h00);
    chk(8'(audio_muted), 8'h00);
    wr(OFS_RAMP_NORMAL, 8'h33);
    cur = 8'h00;
    wr(OFS_VOLUME_LEVEL, 8'h10);
    ramp(8'h10, 1, 1, 4);
    wr(OFS_VOLUME_LEVEL, 8'h02);
    ramp(8'h02, 1, 1, 400);
  endtask
  task automatic t_emergency();
    wr(OFS_RAMP_EMERG, 8'h40);
    emergency_mute = 1'b1;
    clks(3);
    ramp(8'hff, 2, 8, 400);
    chk(8'(audio_muted), 8'h01);
    wr(OFS_RAMP_NORMAL, 8'h0c);
    emergency_mute = 1'b0;
    clks(4);
    chk(left_gain_code, 8'h02);
    wr(OFS_RAMP_EMERG, 8'hc0);
    emergency_mute = 1'b1;
    clks(4);
    chk(left_gain_code, VOL_MUTE_CODE);
    chk(8'(audio_muted), 8'h01);
    emergency_mute = 1'b0;
  endtask
  initial begin
    clks(16);
    reset = 1'b0;
    t_reset_values();
    t_program_coeff();
    t_highz();
    t_ramp_steps();
    t_instant_restart();
    t_emergency();
    final_report();
  end
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule
